// file: hw/pcg_regs.svh
// Register offsets, field positions, reset values and sleep encodings for clock gating
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH
`define PCG_GATE_OFFSET 4'h0
`define PCG_SLEEP_OFFSET 4'h4
`define PCG_STATUS_OFFSET 4'h8
`define PCG_GATE_RESET 8'h00
`define PCG_SLEEP_RESET 4'h0
`define PCG_BIT_PSC2 7
`define PCG_BIT_PSC1 6
`define PCG_BIT_PSC0 5
`define PCG_BIT_TIM1 4
`define PCG_BIT_TIM0 3
`define PCG_BIT_SPI 2
`define PCG_BIT_USART 1
`define PCG_BIT_ADC 0
`define PCG_SLEEP_EN_BIT 0
`define PCG_MODE_IDLE 3'h0
`define PCG_MODE_ADCNR 3'h1
`define PCG_MODE_PDOWN 3'h2
`define PCG_MODE_STANDBY 3'h6
`define PCG_RESP_OKAY 2'h0
`define PCG_RESP_SLVERR 2'h2
`endif

// file: hw/pcg_pkg.sv
// Types shared by the peripheral clock gating block
package pcg_pkg;
    typedef enum logic [1:0] {
        PCG_WIDLE = 2'h0,
        PCG_WRESP = 2'h1
    } pcg_wst_t;
    typedef enum logic [1:0] {
        PCG_RIDLE = 2'h0,
        PCG_RRESP = 2'h1
    } pcg_rst_t;
    // Analog side requests into the block
    typedef struct packed {
        logic adc_enabled;
        logic comp_enabled;
        logic comp_uses_ref;
        logic comp_uses_adc_mux;
        logic bod_fuse_on;
        logic wdt_enabled;
        logic debug_enable_fuse;
        logic wake_pins_needed;
    } pcg_ana_in_t;
    // Power and clock controls out of the block
    typedef struct packed {
        logic [7:0] periph_clk_en;
        logic [7:0] periph_io_block;
        logic cpu_clk_en;
        logic flash_clk_en;
        logic io_clk_en;
        logic adc_clk_en;
        logic main_osc_en;
        logic adc_keep_on;
        logic adc_long_conv;
        logic comp_power;
        logic comp_mux_allow;
        logic vref_en;
        logic bod_active;
        logic wdt_active;
        logic inbuf_en;
        logic wake_inbuf_en;
    } pcg_ctl_out_t;
    typedef struct packed {
        pcg_wst_t wst;
        pcg_rst_t rst;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] gate;
        logic [3:0] sleep;
        logic adc_was_on;
        logic adc_long;
    } pcg_state_t;
endpackage

// file: hw/pcg_top.sv
// Peripheral clock gating controller with AXI4-Lite register access
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "pcg_regs.svh"
//////////////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - A set gating bit freezes its peripheral and blocks its register access.
// - Clearing a gating bit restarts the clock, peripheral resumes its held state.
// - Resources held at clock stop remain occupied; disable before gating.
// - Bits 7, 6, 5 stop power stage controllers 2, 1, 0.
// - Bits 4 and 3 gate timers 1 and 0; they continue as before.
// - Bit 2 stops the SPI clock.
// - Bit 1 stops the USART clock.
// - Bit 0 stops the ADC clock; ADC must be disabled first.
// - Comparator cannot use the ADC input multiplexer while ADC clock gated.
// - Gating acts in active and idle; other sleep modes stop clocks anyway. Here bit 0 also gates the ADC clock in noise reduction.
// - Enabled ADC stays on in sleep; first conversion after re-enable is extended.
// - Comparator auto-disabled in sleep modes other than idle and noise reduction.
// - Comparator using internal reference keeps reference on in any sleep mode.
// - Reference on when brown-out, comparator or ADC need it, else off.
// - Fuse-enabled brown-out detector stays active in all sleep modes.
// - Enabled watchdog stays active in all sleep modes.
// - With I/O and ADC clocks stopped, input buffers off except wake-up ones.
// - Debug fuse keeps the main clock source running during sleep.
// - Idle halts CPU and flash; noise reduction adds I/O; power-down halts all.
module pcg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_req,
    input wire pcg_pkg::pcg_ana_in_t ana_in,
    output pcg_pkg::pcg_ctl_out_t ctl_out
);
    import pcg_pkg::*;

    pcg_state_t st_r;
    pcg_state_t st_nxt;
    logic asleep;
    logic [2:0] mode;
    logic do_write;
    logic do_read;
    logic [3:0] sel_rd;

    //////////////////////////////////////////////////////////////////////////////////////
    // Sleep decode: the CPU side asserts sleep_req while the sleep enable bit is set
    assign mode = st_r.sleep[3:1];
    assign asleep = sleep_req && st_r.sleep[`PCG_SLEEP_EN_BIT];

    // Accept both write channels together so address and data never separate
    assign do_write = (st_r.wst == PCG_WIDLE) && s_axi_awvalid && s_axi_wvalid;
    assign s_axi_awready = do_write;
    assign s_axi_wready = do_write;
    assign do_read = (st_r.rst == PCG_RIDLE) && s_axi_arvalid;
    assign s_axi_arready = do_read;
    assign sel_rd = s_axi_araddr;

    assign s_axi_bvalid = (st_r.wst == PCG_WRESP);
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_rvalid = (st_r.rst == PCG_RRESP);
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;

    //////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic for bus, registers and ADC extended-conversion tracking
    always_comb begin
        st_nxt = st_r;
        unique case (st_r.wst)
            PCG_WIDLE: begin
                if (do_write) begin
                    st_nxt.wst = PCG_WRESP;
                    st_nxt.bresp = `PCG_RESP_OKAY;
                    if (s_axi_awaddr == `PCG_GATE_OFFSET) begin
                        if (s_axi_wstrb[0]) begin
                            st_nxt.gate = s_axi_wdata[7:0];
                        end
                    end else if (s_axi_awaddr == `PCG_SLEEP_OFFSET) begin
                        if (s_axi_wstrb[0]) begin
                            st_nxt.sleep = s_axi_wdata[3:0];
                        end
                    end else if (s_axi_awaddr != `PCG_STATUS_OFFSET) begin
                        st_nxt.bresp = `PCG_RESP_SLVERR;
                    end
                end
            end
            PCG_WRESP: begin
                if (s_axi_bready) begin
                    st_nxt.wst = PCG_WIDLE;
                end
            end
            default: st_nxt.wst = PCG_WIDLE;
        endcase
        unique case (st_r.rst)
            PCG_RIDLE: begin
                if (do_read) begin
                    st_nxt.rst = PCG_RRESP;
                    st_nxt.rresp = `PCG_RESP_OKAY;
                    st_nxt.rdata = 32'h00000000;
                    if (sel_rd == `PCG_GATE_OFFSET) begin
                        st_nxt.rdata = {24'h000000, st_r.gate};
                    end else if (sel_rd == `PCG_SLEEP_OFFSET) begin
                        st_nxt.rdata = {28'h0000000, st_r.sleep};
                    end else if (sel_rd == `PCG_STATUS_OFFSET) begin
                        st_nxt.rdata = {16'h0000, ctl_out.vref_en, ctl_out.comp_power,
                            ctl_out.adc_long_conv, ctl_out.inbuf_en, ctl_out.io_clk_en,
                            ctl_out.adc_clk_en, ctl_out.cpu_clk_en, ctl_out.main_osc_en,
                            ctl_out.periph_clk_en};
                    end else begin
                        st_nxt.rresp = `PCG_RESP_SLVERR;
                    end
                end
            end
            PCG_RRESP: begin
                if (s_axi_rready) begin
                    st_nxt.rst = PCG_RIDLE;
                end
            end
            default: st_nxt.rst = PCG_RIDLE;
        endcase
        // Off-then-on of the ADC arms an extended first conversion
        st_nxt.adc_was_on = ana_in.adc_enabled;
        if (ana_in.adc_enabled && !st_r.adc_was_on) begin
            st_nxt.adc_long = 1'b1;
        end else if (!ana_in.adc_enabled) begin
            st_nxt.adc_long = 1'b0;
        end
    end

    // Single state register; synchronous reset clears every gating bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r.wst <= PCG_WIDLE;
            st_r.rst <= PCG_RIDLE;
            st_r.bresp <= 2'h0;
            st_r.rresp <= 2'h0;
            st_r.rdata <= 32'h00000000;
            st_r.gate <= `PCG_GATE_RESET;
            st_r.sleep <= `PCG_SLEEP_RESET;
            st_r.adc_was_on <= 1'b0;
            st_r.adc_long <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Domain clocks per sleep mode; reserved codes behave as power-down for safety
    logic io_run;
    logic adc_run;
    always_comb begin
        ctl_out = '0;
        io_run = 1'b1;
        adc_run = 1'b1;
        if (asleep) begin
            unique case (mode)
                `PCG_MODE_IDLE: begin
                    io_run = 1'b1;
                    adc_run = 1'b1;
                end
                `PCG_MODE_ADCNR: begin
                    io_run = 1'b0;
                    adc_run = 1'b1;
                end
                default: begin
                    io_run = 1'b0;
                    adc_run = 1'b0;
                end
            endcase
        end
        ctl_out.cpu_clk_en = !asleep;
        ctl_out.flash_clk_en = !asleep;
        ctl_out.io_clk_en = io_run;
        // Oscillator stays up in idle, noise reduction, standby, or with debug fuse
        ctl_out.main_osc_en = !asleep || adc_run || (mode == `PCG_MODE_STANDBY)
            || ana_in.debug_enable_fuse;
        // Gating only matters while the I/O clock runs; otherwise it is already off
        ctl_out.periph_clk_en = io_run ? ~st_r.gate : 8'h00;
        // Gated peripherals refuse register access; state held, not reset
        ctl_out.periph_io_block = st_r.gate;
        ctl_out.adc_clk_en = adc_run && !st_r.gate[`PCG_BIT_ADC];
        ctl_out.adc_keep_on = ana_in.adc_enabled;
        ctl_out.adc_long_conv = st_r.adc_long;
        // Comparator powered in run, idle and noise reduction only; holding the ref does not keep it on
        ctl_out.comp_power = ana_in.comp_enabled && (!asleep || adc_run);
        ctl_out.comp_mux_allow = ana_in.comp_uses_adc_mux
            && !st_r.gate[`PCG_BIT_ADC];
        ctl_out.vref_en = ana_in.bod_fuse_on || ana_in.adc_enabled
            || (ana_in.comp_enabled && ana_in.comp_uses_ref);
        ctl_out.bod_active = ana_in.bod_fuse_on;
        ctl_out.wdt_active = ana_in.wdt_enabled;
        ctl_out.inbuf_en = io_run || adc_run;
        ctl_out.wake_inbuf_en = ctl_out.inbuf_en || ana_in.wake_pins_needed;
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_write_gate;
        do_write && (s_axi_awaddr == `PCG_GATE_OFFSET) && s_axi_wstrb[0];
    endsequence
    a_gate_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
        s_write_gate |=> st_r.gate == $past(s_axi_wdata[7:0]))
        else $error("gate register did not take written value");
    a_gate_stops_clk: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.gate[`PCG_BIT_SPI] |-> !ctl_out.periph_clk_en[`PCG_BIT_SPI])
        else $error("spi clock runs while gated");
    a_ungate_runs: assert property (@(posedge aclk) disable iff (!aresetn)
        (!st_r.gate[`PCG_BIT_TIM1] && !asleep) |-> ctl_out.periph_clk_en[`PCG_BIT_TIM1])
        else $error("timer clock stopped while ungated");
    a_adc_mux_block: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.gate[`PCG_BIT_ADC] |-> !ctl_out.comp_mux_allow && !ctl_out.adc_clk_en)
        else $error("adc mux usable while adc clock gated");
    a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write |=> s_axi_bvalid)
        else $error("write response missing");
    // Response must stand until the master takes it
    a_bresp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
        else $error("write response dropped before taken");
    a_read_back: assert property (@(posedge aclk) disable iff (!aresetn)
        (do_read && sel_rd == `PCG_GATE_OFFSET) |=> s_axi_rdata[7:0] == $past(st_r.gate))
        else $error("gate readback mismatch");
    a_long_conv: assert property (@(posedge aclk) disable iff (!aresetn)
        (ana_in.adc_enabled && !st_r.adc_was_on) |=> st_r.adc_long)
        else $error("extended conversion not armed");
    a_vref_need: assert property (@(posedge aclk) disable iff (!aresetn)
        ctl_out.vref_en == (ana_in.bod_fuse_on || ana_in.adc_enabled
        || (ana_in.comp_enabled && ana_in.comp_uses_ref)))
        else $error("reference enable wrong");
    a_pdown_clocks: assert property (@(posedge aclk) disable iff (!aresetn)
        (asleep && mode == `PCG_MODE_PDOWN && !ana_in.debug_enable_fuse)
        |-> !ctl_out.io_clk_en && !ctl_out.adc_clk_en && !ctl_out.main_osc_en)
        else $error("power-down left a clock running");
    a_debug_osc: assert property (@(posedge aclk) disable iff (!aresetn)
        ana_in.debug_enable_fuse |-> ctl_out.main_osc_en)
        else $error("oscillator stopped with debug fuse");
endmodule

// file: sim/pcg_periph_model.sv
// Behavioural stand-ins for the clock-gated peripherals, one counter lane each
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
module pcg_periph_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] clk_en,
    input wire logic [7:0] io_block,
    output logic [63:0] cnt,
    output logic clash
);
    // A lane advances only while its clock runs; a stopped lane keeps its state
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 8; i++) begin
            if (!aresetn) begin
                cnt[i*8 +: 8] <= 8'h00;
            end else if (clk_en[i]) begin
                cnt[i*8 +: 8] <= cnt[i*8 +: 8] + 8'h01;
            end
        end
    end
    // Blocked register access on a running lane would let software see a moving target
    assign clash = |(clk_en & io_block);
endmodule

// file: sim/pcg_top_tb_top.sv
// Self-checking bench for the peripheral clock gating controller
`timescale 1ns/1ps
`include "pcg_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end
////////////////////////////////////////////////////////////
module pcg_top_tb_top;
    import pcg_pkg::*;
    typedef struct packed {logic [7:0] gate; logic [7:0] run;} pcg_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic sleep_req = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, clash;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd_val;
    logic [63:0] cnt;
    logic [7:0] held, held2;
    logic io_on, adc_on;
    pcg_ana_in_t ana_in = '0; // ADC stays disabled while its clock is gated
    pcg_ctl_out_t ctl;
    int n_mismatch = 0;
    int cmp_count = 0;
    pcg_row_t rows [9] = '{'{8'h80, 8'h7F}, '{8'h40, 8'hBF}, '{8'h20, 8'hDF},
        '{8'h10, 8'hEF}, '{8'h08, 8'hF7}, '{8'h04, 8'hFB}, '{8'h02, 8'hFD},
        '{8'h01, 8'hFE}, '{8'h00, 8'hFF}};
    logic [2:0] modes [3] = '{`PCG_MODE_IDLE, `PCG_MODE_ADCNR, `PCG_MODE_PDOWN};

    pcg_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sleep_req(sleep_req), .ana_in(ana_in), .ctl_out(ctl));
    pcg_periph_model u_model (.aclk(aclk), .aresetn(aresetn), .clk_en(ctl.periph_clk_en),
        .io_block(ctl.periph_io_block), .cnt(cnt), .clash(clash));

    ////////////////////////////////////////////////////////////
    // Clock at 50 ns period
    initial begin
        forever #25 aclk = ~aclk;
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        tally_and_finish();
    end

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Let the edge's updates land before looking
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        r = 2'h3;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) begin
            n_mismatch++;
            tally_and_finish();
        end
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        r = 2'h3;
        d = 32'h0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 64 && !done; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) begin
            n_mismatch++;
            tally_and_finish();
        end
        #1;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        step(1);
        rd(`PCG_GATE_OFFSET, rd_val, resp);
        `CHK(rd_val[7:0], `PCG_GATE_RESET)
        rd(`PCG_SLEEP_OFFSET, rd_val, resp);
        `CHK(rd_val[3:0], `PCG_SLEEP_RESET)
        `CHK(ctl.periph_clk_en, 8'hFF)
        // Each gating bit alone, read back and seen at the clock lanes
        foreach (rows[i]) begin
            wr(`PCG_GATE_OFFSET, {24'h0, rows[i].gate}, resp);
            rd(`PCG_GATE_OFFSET, rd_val, resp);
            `CHK(rd_val[7:0], rows[i].gate)
            `CHK(ctl.periph_clk_en, rows[i].run)
            `CHK(ctl.periph_io_block, rows[i].gate)
            `CHK(clash, 1'b0)
        end
        // Timer 0 lane holds its count while gated and counts on once ungated
        wr(`PCG_GATE_OFFSET, 32'h08, resp);
        held = cnt[31:24];
        step(5);
        `CHK(cnt[31:24], held)
        wr(`PCG_GATE_OFFSET, 32'h00, resp);
        held2 = cnt[31:24];
        step(1);
        `CHK(cnt[31:24], held2 + 8'h01)
        `CHK((held2 - held) < 8'h08, 1'b1)
        // Comparator borrowing the converter multiplexer
        @(posedge aclk);
        ana_in.comp_enabled <= 1'b1;
        ana_in.comp_uses_adc_mux <= 1'b1;
        wr(`PCG_GATE_OFFSET, 32'h01, resp);
        `CHK(ctl.comp_mux_allow, 1'b0)
        wr(`PCG_GATE_OFFSET, 32'h00, resp);
        `CHK(ctl.comp_mux_allow, 1'b1)
        // Unmapped place refused without side effects
        wr(4'hC, 32'hFF, resp);
        `CHK(resp, `PCG_RESP_SLVERR)
        rd(4'hC, rd_val, resp);
        `CHK(resp, `PCG_RESP_SLVERR)
        rd(`PCG_GATE_OFFSET, rd_val, resp);
        `CHK(rd_val[7:0], 8'h00)
        // Converter switched on again: first conversion is the long one
        @(posedge aclk);
        ana_in.adc_enabled <= 1'b1;
        ana_in.bod_fuse_on <= 1'b1;
        ana_in.wdt_enabled <= 1'b1;
        step(2);
        `CHK(ctl.adc_long_conv, 1'b1)
        // SPI kept gated across the sleep modes
        wr(`PCG_GATE_OFFSET, 32'h04, resp);
        for (int m = 0; m < 3; m++) begin
            io_on = (m == 0);
            adc_on = (m < 2);
            wr(`PCG_SLEEP_OFFSET, {28'h0, modes[m], 1'b1}, resp);
            @(posedge aclk);
            sleep_req <= 1'b1;
            step(1);
            `CHK({ctl.cpu_clk_en, ctl.flash_clk_en}, 2'b00)
            `CHK({ctl.io_clk_en, ctl.adc_clk_en, ctl.main_osc_en}, {io_on, adc_on, adc_on})
            `CHK(ctl.inbuf_en, io_on | adc_on)
            `CHK(ctl.comp_power, adc_on)
            `CHK({ctl.bod_active, ctl.wdt_active, ctl.adc_keep_on}, 3'h7)
            if (m == 0) `CHK(ctl.periph_clk_en, 8'hFB)
        end
        // Standby keeps only the oscillator; the status word shows the clock picture
        wr(`PCG_SLEEP_OFFSET, {28'h0, `PCG_MODE_STANDBY, 1'b1}, resp);
        `CHK({ctl.io_clk_en, ctl.adc_clk_en, ctl.main_osc_en}, 3'b001)
        rd(`PCG_STATUS_OFFSET, rd_val, resp);
        `CHK(rd_val[15:0], 16'hA100)
        wr(`PCG_SLEEP_OFFSET, {28'h0, `PCG_MODE_PDOWN, 1'b1}, resp);
        `CHK(ctl.main_osc_en, 1'b0)
        // Still in power-down: debug fuse, wake pins and comparator reference
        @(posedge aclk);
        ana_in.debug_enable_fuse <= 1'b1;
        ana_in.wake_pins_needed <= 1'b1;
        ana_in.comp_uses_ref <= 1'b1;
        ana_in.bod_fuse_on <= 1'b0;
        ana_in.adc_enabled <= 1'b0;
        step(1);
        `CHK(ctl.main_osc_en, 1'b1)
        `CHK(ctl.wake_inbuf_en, 1'b1)
        `CHK(ctl.vref_en, 1'b1)
        @(posedge aclk);
        sleep_req <= 1'b0;
        ana_in <= '0;
        step(1);
        `CHK(ctl.vref_en, 1'b0)
        `CHK(ctl.cpu_clk_en, 1'b1)
        // Reset in mid-run brings every clock back
        wr(`PCG_GATE_OFFSET, 32'hFF, resp);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        step(1);
        `CHK(ctl.periph_clk_en, 8'hFF)
        rd(`PCG_GATE_OFFSET, rd_val, resp);
        `CHK(rd_val[7:0], 8'h00)
        tally_and_finish();
    end
endmodule
